// >>> rtl/pfr_pkg.sv
// constants for the processor-temperature polling and fan-ramp registers
package pfr_pkg;
	localparam logic [7:0] OFS_POLL_CFG = 8'h37;
	localparam logic [7:0] OFS_CEIL1 = 8'h38;
	localparam logic [7:0] OFS_CEIL2 = 8'h39;
	localparam logic [7:0] OFS_CEIL3 = 8'h3a;
	localparam logic [7:0] OFS_RAMP_START = 8'h3b;
	localparam logic [7:0] OFS_RAMP_SPAN = 8'h3c;
	localparam logic [7:0] RST_POLL_CFG = 8'h32;
	localparam logic [7:0] RST_CEIL = 8'hff;
	localparam logic [7:0] RST_RAMP_START = 8'h80;
	localparam logic [7:0] RST_RAMP_SPAN = 8'hc0;
	localparam logic [7:0] POLL_CFG_WMASK = 8'hb3;
	localparam logic [7:0] POLL_CFG_RSVD_KEEP = 8'h00;
	localparam logic [7:0] SPAN_WMASK = 8'hf0;
	localparam int BIT_FOUND = 0;
	localparam int BIT_RETRY_SUPPRESS = 1;
	localparam int BIT_RATE_LO = 4;
	localparam int BIT_WRITE_PERMIT = 7;
	localparam int CLK_MHZ = 200;
	localparam int POLL_PERIOD_1_MS = 1000;
	localparam int POLL_PERIOD_2_MS = 500;
	localparam int POLL_PERIOD_5_MS = 200;
	localparam int POLL_PERIOD_10_MS = 100;
	localparam int CYC_PER_MS = CLK_MHZ * 1000;
	localparam int POLL_CYC_1 = POLL_PERIOD_1_MS * CYC_PER_MS;
	localparam int POLL_CYC_2 = POLL_PERIOD_2_MS * CYC_PER_MS;
	localparam int POLL_CYC_5 = POLL_PERIOD_5_MS * CYC_PER_MS;
	localparam int POLL_CYC_10 = POLL_PERIOD_10_MS * CYC_PER_MS;
	localparam int SPAN_Q_FRAC = 4;
	typedef logic [1:0] pfr_rate_t;
endpackage

// >>> rtl/pfr_regs.sv
// register bank for processor polling configuration, duty ceilings and fan ramp
`timescale 1ns/10ps
`default_nettype none
module pfr_regs
	import pfr_pkg::*;
#(
	parameter int POLL_CYC_1HZ = POLL_CYC_1,
	parameter int POLL_CYC_2HZ = POLL_CYC_2,
	parameter int POLL_CYC_5HZ = POLL_CYC_5,
	parameter int POLL_CYC_10HZ = POLL_CYC_10
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic WR_EN,
	input wire logic RD_EN,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	output logic [7:0] RDATA,
	output logic RVALID,
	input wire logic POLL_ENABLE,
	input wire logic LIMIT_LOCK,
	output logic POLL_ENABLE_EFF,
	input wire logic PROC_FOUND,
	input wire logic BAD_COMPLETION,
	input wire logic CMD_DONE,
	output logic RETRY_BIT,
	output logic POLL_TICK,
	input wire logic WRITE_REQ,
	output logic WRITE_GRANT,
	input wire logic [7:0] PWM1_RAW,
	input wire logic [7:0] PWM2_RAW,
	input wire logic [7:0] PWM3_RAW,
	output logic [7:0] PWM1_DUTY,
	output logic [7:0] PWM2_DUTY,
	output logic [7:0] PWM3_DUTY,
	input wire logic [7:0] CPU_TEMP,
	input wire logic [7:0] FLOOR_DUTY,
	output logic [7:0] RAMP_DUTY,
	output logic [11:0] SPAN_C_Q4
);
	logic [7:0] cfg_q, cfg_d;
	logic [7:0] ceil_q [3];
	logic [7:0] start_q;
	logic [7:0] span_q;
	logic enable_q;
	logic after_bad_q;
	logic [31:0] tick_cnt_q;

	function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lim);
		clamp = (v > lim) ? lim : v;
	endfunction

	// span in quarter degrees, fractions rounded to nearest quarter
	function automatic logic [11:0] span_q4(input logic [3:0] code);
		unique case (code)
			4'h0: span_q4 = 12'd8;
			4'h1: span_q4 = 12'd10;
			4'h2: span_q4 = 12'd13;
			4'h3: span_q4 = 12'd16;
			4'h4: span_q4 = 12'd20;
			4'h5: span_q4 = 12'd27;
			4'h6: span_q4 = 12'd32;
			4'h7: span_q4 = 12'd40;
			4'h8: span_q4 = 12'd53;
			4'h9: span_q4 = 12'd64;
			4'ha: span_q4 = 12'd80;
			4'hb: span_q4 = 12'd107;
			4'hc: span_q4 = 12'd128;
			4'hd: span_q4 = 12'd160;
			4'he: span_q4 = 12'd240;
			4'hf: span_q4 = 12'd320;
		endcase
	endfunction

	wire wr_cfg = WR_EN && ADDR == OFS_POLL_CFG;
	wire wr_start = WR_EN && ADDR == OFS_RAMP_START;
	wire wr_span = WR_EN && ADDR == OFS_RAMP_SPAN;
	wire [2:0] wr_ceil = {WR_EN && ADDR == OFS_CEIL3, WR_EN && ADDR == OFS_CEIL2,
		WR_EN && ADDR == OFS_CEIL1};
	wire [3:0] span_code = span_q[7:4];
	wire [11:0] span_now = span_q4(span_code);
	wire pfr_rate_t rate = cfg_q[BIT_RATE_LO+1:BIT_RATE_LO];
	wire [31:0] period = (rate == 2'h0) ? 32'(POLL_CYC_1HZ) :
		(rate == 2'h1) ? 32'(POLL_CYC_2HZ) :
		(rate == 2'h2) ? 32'(POLL_CYC_5HZ) : 32'(POLL_CYC_10HZ);
	wire tick_now = enable_q && tick_cnt_q >= period - 32'd1;
	wire above = CPU_TEMP > start_q;
	wire [8:0] excess = {1'b0, CPU_TEMP} - {1'b0, start_q};
	// slope: (255-floor) over span, excess in C so scale by 4 for quarters
	wire [19:0] rise_num = 20'(excess[7:0]) * 20'(8'hff - FLOOR_DUTY) * 20'd4;
	wire [19:0] rise = rise_num / 20'(span_now);
	wire [8:0] ramp_sum = {1'b0, FLOOR_DUTY} + ((rise > 20'd255) ? 9'd255 : 9'(rise));
	wire [7:0] ramp_val = (ramp_sum > 9'd255) ? 8'hff : ramp_sum[7:0];
	wire [7:0] ramp_d = above ? ramp_val : 8'h00;
	wire [7:0] rd_mux = (ADDR == OFS_POLL_CFG) ? cfg_q :
		(ADDR == OFS_CEIL1) ? ceil_q[0] :
		(ADDR == OFS_CEIL2) ? ceil_q[1] :
		(ADDR == OFS_CEIL3) ? ceil_q[2] :
		(ADDR == OFS_RAMP_START) ? start_q :
		(ADDR == OFS_RAMP_SPAN) ? span_q : 8'h00;

	// found flag follows the link, reserved bits held at zero
	always_comb begin
		cfg_d = cfg_q;
		if (wr_cfg) begin
			cfg_d = (WDATA & POLL_CFG_WMASK) | POLL_CFG_RSVD_KEEP;
		end
		cfg_d[BIT_FOUND] = PROC_FOUND;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			cfg_q <= RST_POLL_CFG;
			start_q <= RST_RAMP_START;
			span_q <= RST_RAMP_SPAN;
		end else begin
			cfg_q <= cfg_d;
			if (wr_start) begin
				start_q <= WDATA;
			end
			// span field writable, low nibble reserved
			if (wr_span) begin
				span_q <= WDATA & SPAN_WMASK;
			end
		end
	end

	// one ceiling per output, reset full duty
	// one process for the whole array, so it has a single driver
	always_ff @(posedge CLK) begin
		for (int i = 0; i < 3; i++) begin
			if (RST) begin
				ceil_q[i] <= RST_CEIL;
			end else if (wr_ceil[i]) begin
				ceil_q[i] <= WDATA;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			enable_q <= 1'b0;
			after_bad_q <= 1'b0;
			tick_cnt_q <= '0;
			RDATA <= 8'h00;
			RVALID <= 1'b0;
			POLL_ENABLE_EFF <= 1'b0;
			RETRY_BIT <= 1'b0;
			POLL_TICK <= 1'b0;
			WRITE_GRANT <= 1'b0;
			PWM1_DUTY <= 8'h00;
			PWM2_DUTY <= 8'h00;
			PWM3_DUTY <= 8'h00;
			RAMP_DUTY <= 8'h00;
			SPAN_C_Q4 <= 12'd0;
		end else begin
			// enable frozen while limits are locked
			if (!LIMIT_LOCK) begin
				enable_q <= POLL_ENABLE;
			end
			POLL_ENABLE_EFF <= enable_q;
			// new bad completion wins over a completion in the same cycle
			if (BAD_COMPLETION) begin
				after_bad_q <= 1'b1;
			end else if (CMD_DONE) begin
				after_bad_q <= 1'b0;
			end
			RETRY_BIT <= (after_bad_q || BAD_COMPLETION) && !cfg_q[BIT_RETRY_SUPPRESS];
			if (!enable_q || tick_now) begin
				tick_cnt_q <= '0;
			end else begin
				tick_cnt_q <= tick_cnt_q + 32'd1;
			end
			POLL_TICK <= tick_now;
			WRITE_GRANT <= WRITE_REQ && cfg_q[BIT_WRITE_PERMIT] && enable_q;
			PWM1_DUTY <= clamp(PWM1_RAW, ceil_q[0]);
			PWM2_DUTY <= clamp(PWM2_RAW, ceil_q[1]);
			PWM3_DUTY <= clamp(PWM3_RAW, ceil_q[2]);
			// zero at or below start, above it floor duty plus a rise with temperature
			RAMP_DUTY <= ramp_d;
			SPAN_C_Q4 <= span_now;
			RDATA <= RD_EN ? rd_mux : 8'h00;
			RVALID <= RD_EN;
		end
	end

	a_ceil_clamp: assert property (@(posedge CLK) disable iff (RST) ##1 PWM1_DUTY <= $past(ceil_q[0])) else $error("pwm1 above ceiling");
	a_write_gate: assert property (@(posedge CLK) disable iff (RST) WRITE_GRANT |-> $past(cfg_q[BIT_WRITE_PERMIT])) else $error("write granted without permit");
	a_retry_off: assert property (@(posedge CLK) disable iff (RST) $past(cfg_q[BIT_RETRY_SUPPRESS]) |-> !RETRY_BIT) else $error("retry set while suppressed");
	a_retry_on: assert property (@(posedge CLK) disable iff (RST) BAD_COMPLETION && !cfg_q[BIT_RETRY_SUPPRESS] |=> RETRY_BIT) else $error("retry missing after bad code");
	a_found_flag: assert property (@(posedge CLK) disable iff (RST) ##1 cfg_q[BIT_FOUND] == $past(PROC_FOUND)) else $error("found flag stale");
	a_lock_hold: assert property (@(posedge CLK) disable iff (RST) LIMIT_LOCK |=> $stable(enable_q)) else $error("enable changed under lock");
	a_tick_off: assert property (@(posedge CLK) disable iff (RST) !enable_q |=> !POLL_TICK) else $error("poll tick while disabled");
	a_ramp_idle: assert property (@(posedge CLK) disable iff (RST) !above |=> RAMP_DUTY == 8'h00) else $error("ramp active below start");
	a_ramp_floor: assert property (@(posedge CLK) disable iff (RST) above |=> RAMP_DUTY >= $past(FLOOR_DUTY)) else $error("ramp below floor");
	a_rsvd_zero: assert property (@(posedge CLK) disable iff (RST) (cfg_q & 8'h4c) == 8'h00 && span_q[3:0] == 4'h0) else $error("reserved bits set");
	a_span_rst: assert property (@(posedge CLK) $fell(RST) |-> span_now == 12'd128) else $error("span reset not 32 C");
	c_tick: cover property (@(posedge CLK) disable iff (RST) POLL_TICK);
	c_grant: cover property (@(posedge CLK) disable iff (RST) WRITE_GRANT);
	c_retry: cover property (@(posedge CLK) disable iff (RST) RETRY_BIT);
	c_ramp: cover property (@(posedge CLK) disable iff (RST) RAMP_DUTY == 8'hff);
endmodule
`default_nettype wire

// >>> dv/pfr_link_model.sv
// processor-side link model answering each poll
`timescale 1ns/10ps
`default_nettype none
module pfr_link_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic poll_tick,
	input wire logic present,
	input wire logic fail,
	output logic proc_found,
	output logic bad_completion,
	output logic cmd_done
);
	logic [1:0] ph_q;
	assign proc_found = present;
	// bad code one cycle after poll, command ends two later
	always_ff @(posedge clk) begin
		if (rst) begin
			ph_q <= 2'h0;
			bad_completion <= 1'b0;
			cmd_done <= 1'b0;
		end else begin
			ph_q <= {ph_q[0], poll_tick};
			bad_completion <= poll_tick & fail;
			cmd_done <= ph_q[1];
		end
	end
endmodule
`default_nettype wire

// >>> dv/peci_fan_ramp_config_tb_top.sv
// self-checking bench for the polling and fan-ramp register bank
`timescale 1ns/10ps
`default_nettype none
module peci_fan_ramp_config_tb_top;
	import pfr_pkg::*;
	logic clk = 0, rst = 1, wr_en = 0, rd_en = 0, pe = 0, lock = 0, present = 0, fail = 0;
	logic wreq = 0, found, bad, done, pe_eff, retry, tick, grant, rvalid;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d1, d2, d3, ramp, r;
	logic [7:0] raw = 8'h50, temp = 8'h00, floor_d = 8'h10;
	logic [11:0] span;
	int mismatches = 0, total_checks = 0, n;
	logic [7:0] rows [9][3] = '{'{8'h37, 8'hff, 8'hb2}, '{8'h37, 8'h32, 8'h32},
		'{8'h38, 8'h40, 8'h40}, '{8'h39, 8'h00, 8'h00}, '{8'h3a, 8'h7f, 8'h7f},
		'{8'h3b, 8'h5a, 8'h5a}, '{8'h3c, 8'hff, 8'hf0}, '{8'h3c, 8'hc5, 8'hc0},
		'{8'h50, 8'h12, 8'h00}};
	logic [7:0] rst_v [6] = '{8'h32, 8'hff, 8'hff, 8'hff, 8'h80, 8'hc0};
	logic [11:0] span_q4 [16] = '{12'h008, 12'h00a, 12'h00d, 12'h010, 12'h014, 12'h01b,
		12'h020, 12'h028, 12'h035, 12'h040, 12'h050, 12'h06b, 12'h080, 12'h0a0,
		12'h0f0, 12'h140};
	always #2.5 clk = ~clk;
	pfr_regs #(.POLL_CYC_1HZ(10), .POLL_CYC_2HZ(8), .POLL_CYC_5HZ(6), .POLL_CYC_10HZ(4)) dut (
		.CLK(clk), .RST(rst), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr), .WDATA(wdata),
		.RDATA(rdata), .RVALID(rvalid), .POLL_ENABLE(pe), .LIMIT_LOCK(lock),
		.POLL_ENABLE_EFF(pe_eff), .PROC_FOUND(found), .BAD_COMPLETION(bad),
		.CMD_DONE(done), .RETRY_BIT(retry), .POLL_TICK(tick), .WRITE_REQ(wreq),
		.WRITE_GRANT(grant), .PWM1_RAW(raw), .PWM2_RAW(raw), .PWM3_RAW(raw),
		.PWM1_DUTY(d1), .PWM2_DUTY(d2), .PWM3_DUTY(d3), .CPU_TEMP(temp),
		.FLOOR_DUTY(floor_d), .RAMP_DUTY(ramp), .SPAN_C_Q4(span));
	pfr_link_model link (.clk(clk), .rst(rst), .poll_tick(tick), .present(present),
		.fail(fail), .proc_found(found), .bad_completion(bad), .cmd_done(done));
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [11:0] e, input logic [11:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) {wr_en, addr, wdata} <= {1'b1, a, d};
		@(posedge clk) wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk) {rd_en, addr} <= {1'b1, a};
		@(posedge clk) rd_en <= 1'b0;
		@(negedge clk) v = rdata;
		chk("rvalid", 12'h001, {11'h0, rvalid});
	endtask
	task automatic settle(input int c);
		repeat (c) @(negedge clk);
	endtask
	initial begin
		#200000 mismatches++;
		give_verdict();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rd(8'h37 + 8'(i), r);
			chk("reset value", {4'h0, rst_v[i]}, {4'h0, r});
		end
		foreach (rows[i]) begin
			wr(rows[i][0], rows[i][1]);
			rd(rows[i][0], r);
			chk("reg readback", {4'h0, rows[i][2]}, {4'h0, r});
		end
		@(posedge clk) present <= 1'b1;
		rd(8'h37, r);
		chk("found flag", 12'h001, {11'h0, r[0]});
		foreach (span_q4[i]) begin
			wr(8'h3c, {4'(i), 4'h0});
			settle(2);
			chk("span", span_q4[i], span);
		end
		wr(8'h38, 8'h40);
		wr(8'h39, 8'h80);
		wr(8'h3a, 8'h00);
		settle(2);
		chk("ceil1", 12'h040, {4'h0, d1});
		chk("ceil2", 12'h050, {4'h0, d2});
		chk("ceil3", 12'h000, {4'h0, d3});
		@(posedge clk) pe <= 1'b1;
		// each rate code gives its own tick spacing
		for (int c = 0; c < 4; c++) begin
			wr(8'h37, {2'h0, 2'(c), 4'h0});
			settle(1);
			n = 0;
			repeat (30) if (tick !== 1'b1) @(negedge clk);
			@(negedge clk);
			while (tick !== 1'b1 && n < 30) begin
				n++;
				@(negedge clk);
			end
			chk("tick spacing", 12'(POLL_CYC_10 > 0 ? 10 - 2 * c : 0), 12'(n + 1));
		end
		// retry set after bad code unless suppressed
		@(posedge clk) fail <= 1'b1;
		n = 0;
		while (retry !== 1'b1 && n < 20) begin n++; settle(1); end
		chk("retry set", 12'h001, {11'h0, retry});
		n = 0;
		while (retry !== 1'b0 && n < 20) begin n++; settle(1); end
		chk("retry cleared", 12'h000, {11'h0, retry});
		wr(8'h37, 8'h32);
		// retry for the edge that still saw the old setting
		settle(1);
		r = 8'h0;
		repeat (20) begin settle(1); r[0] = r[0] | retry; end
		chk("retry suppressed", 12'h000, {4'h0, r});
		@(posedge clk) {fail, wreq} <= 2'b01;
		settle(3);
		chk("grant blocked", 12'h000, {11'h0, grant});
		wr(8'h37, 8'hb0);
		settle(2);
		chk("grant given", 12'h001, {11'h0, grant});
		@(posedge clk) {lock, pe} <= 2'b10;
		settle(4);
		chk("locked enable", 12'h001, {11'h0, pe_eff});
		@(posedge clk) lock <= 1'b0;
		settle(4);
		chk("enable off", 12'h000, {11'h0, pe_eff});
		chk("grant off", 12'h000, {11'h0, grant});
		// start set back to 0x80 from 0x5a, inside the valid ceiling of 175 C
		wr(8'h3b, 8'h80);
		wr(8'h3c, 8'h00);
		temp <= 8'h80;
		settle(3);
		chk("ramp off", 12'h000, {4'h0, ramp});
		@(posedge clk) temp <= 8'h81;
		settle(3);
		chk("ramp slope", 12'h087, {4'h0, ramp});
		@(posedge clk) temp <= 8'h90;
		settle(3);
		chk("ramp sat", 12'h0ff, {4'h0, ramp});
		give_verdict();
	end
endmodule
`default_nettype wire
